// ---- logic/iod_alu.sv ----
// Byte adder with status flags for the indexed add
`timescale 1ns/1ps
`default_nettype none
`include "iod_defs.svh"
module iod_alu (
  // Operands
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  // Result
  output logic [7:0] sum,
  output logic [4:0] flags
);
  logic [8:0] full;
  logic [4:0] low;
  assign full = {1'b0, a} + {1'b0, b};
  assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]};
  assign sum = full[7:0];
  assign flags[`IOD_ST_C] = full[8];
  assign flags[`IOD_ST_DC] = low[4];
  assign flags[`IOD_ST_Z] = (full[7:0] == 8'h00);
  assign flags[`IOD_ST_OV] = (a[7] == b[7]) && (full[7] != a[7]);
  assign flags[`IOD_ST_N] = full[7];
endmodule
`default_nettype wire

// ---- logic/iod_decode.sv ----
// Indexed offset operand decode and execute for add, bit set and fill
// Summary of operation
// - Extended mode: offset <=5Fh indexes frame pointer
// - Only a=0; larger offsets stay literal (this code executes no instruction for them; done stays low)
// - Zero frame pointer reaches standard locations
// - Indexed add sums accumulator and memory
// - d=0 to accumulator, d=1 to memory
// - Add updates N, OV, C, DC, Z
// - Add opcode 0010 01d0 kkkk kkkk
// - Bit set touches one bit, no flags
// - Bit set opcode 1000 bbb0 kkkk kkkk
// - Fill writes FFh, no flags
// - Enable bit zero disables extended mode
`timescale 1ns/1ps
`default_nettype none
`include "iod_defs.svh"
module iod_decode #(
  parameter int ADDR_W = 12,
  parameter int MEM_DEPTH = 4096
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Configuration
  input wire logic ext_set_enable_bit,
  // Instruction
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  // Frame pointer load
  input wire logic fp_load,
  input wire logic [ADDR_W-1:0] fp_value,
  // Accumulator load
  input wire logic accum_load,
  input wire logic [7:0] accum_value,
  // Memory preload and read-back
  input wire logic mem_wr,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  // Core state
  output logic [ADDR_W-1:0] frame_pointer,
  output logic [7:0] accum,
  output logic [4:0] status,
  output logic done,
  output logic indexed_hit
);
  // Refuse sizes the address logic cannot serve
  if (ADDR_W < 8 || MEM_DEPTH != (1 << ADDR_W)) begin : g_bad_size
    $error("iod_decode: unsupported ADDR_W or MEM_DEPTH");
  end

  logic [7:0] mem [0:MEM_DEPTH-1];
  logic [ADDR_W-1:0] fp_ff;
  logic [7:0] w_ff;
  logic [4:0] st_ff;
  logic [7:0] rd_ff;
  logic done_ff;
  logic hit_ff;

  // Decode
  wire [7:0] ofs = instr_word[7:0];
  wire access_a0 = ~instr_word[8];
  wire is_add = instr_word[15:10] == `IOD_OP_ADD_HI;
  wire is_bset = instr_word[15:12] == `IOD_OP_BSF_HI;
  wire is_fill = instr_word[15:8] == `IOD_OP_FILL_HI;
  wire ofs_ok = ofs <= `IOD_OFS_MAX;
  wire indexed = ext_set_enable_bit && access_a0 && ofs_ok;
  iod_pkg::iod_op_t op;
  assign op = !(instr_valid && indexed) ? iod_pkg::IOD_OP_NONE :
              is_add ? iod_pkg::IOD_OP_ADD :
              is_fill ? iod_pkg::IOD_OP_FILL :
              is_bset ? iod_pkg::IOD_OP_BSET : iod_pkg::IOD_OP_NONE;

  // Effective address, wraps within data space
  wire [ADDR_W-1:0] eff_addr = fp_ff + ADDR_W'(ofs);
  wire [7:0] cur = mem[eff_addr];
  wire [2:0] bit_sel = instr_word[11:9];
  wire dest_mem = instr_word[9];

  logic [7:0] add_sum;
  logic [4:0] add_flags;
  iod_alu u_alu (
    .a(w_ff),
    .b(cur),
    .sum(add_sum),
    .flags(add_flags)
  );

  wire [7:0] bset_val = cur | (8'h01 << bit_sel);
  wire mem_we_op = (op == iod_pkg::IOD_OP_ADD && dest_mem) ||
                   op == iod_pkg::IOD_OP_BSET || op == iod_pkg::IOD_OP_FILL;
  wire [7:0] op_wdata = (op == iod_pkg::IOD_OP_ADD) ? add_sum :
                        (op == iod_pkg::IOD_OP_FILL) ? `IOD_FILL_VAL : bset_val;

  logic [7:0] nxt_w_ff;
  logic [4:0] nxt_st_ff;
  assign nxt_w_ff = accum_load ? accum_value :
                    (op == iod_pkg::IOD_OP_ADD && !dest_mem) ? add_sum : w_ff;
  assign nxt_st_ff = (op == iod_pkg::IOD_OP_ADD) ? add_flags : st_ff;

  always_ff @(posedge sys_clk) begin
    if (mem_we_op) begin
      mem[eff_addr] <= op_wdata;
    end else if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fp_ff <= ADDR_W'(`IOD_FP_RST);
      w_ff <= `IOD_W_RST;
      st_ff <= `IOD_ST_RST;
      rd_ff <= 8'h00;
      done_ff <= 1'b0;
      hit_ff <= 1'b0;
    end else begin
      fp_ff <= fp_load ? fp_value : fp_ff;
      w_ff <= nxt_w_ff;
      st_ff <= nxt_st_ff;
      rd_ff <= mem[mem_addr];
      done_ff <= op != iod_pkg::IOD_OP_NONE;
      hit_ff <= instr_valid && indexed;
    end
  end

  assign frame_pointer = fp_ff;
  assign accum = w_ff;
  assign status = st_ff;
  assign mem_rdata = rd_ff;
  assign done = done_ff;
  assign indexed_hit = hit_ff;
endmodule
`default_nettype wire

// ---- logic/iod_defs.svh ----
// Constants for the indexed offset operand decoder
`ifndef IOD_DEFS_SVH
`define IOD_DEFS_SVH
`define IOD_OFS_MAX 8'h5F
`define IOD_OP_ADD_HI 6'h09
`define IOD_OP_BSF_HI 4'h8
`define IOD_OP_FILL_HI 8'h68
`define IOD_FILL_VAL 8'hFF
`define IOD_ST_N 4
`define IOD_ST_OV 3
`define IOD_ST_Z 2
`define IOD_ST_DC 1
`define IOD_ST_C 0
`define IOD_FP_RST 12'h000
`define IOD_W_RST 8'h00
`define IOD_ST_RST 5'h00
`endif

// ---- logic/iod_pkg.sv ----
// Types for the indexed offset operand decoder
package iod_pkg;
  typedef enum logic [1:0] {
    IOD_OP_NONE = 2'h0,
    IOD_OP_ADD = 2'h1,
    IOD_OP_BSET = 2'h3,
    IOD_OP_FILL = 2'h2
  } iod_op_t;
endpackage

// ---- tb/iod_chk.sv ----
// Decoder port checks
`timescale 1ns/1ps
`default_nettype none
module iod_chk (
  // Watched ports
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ext_set_enable_bit,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [7:0] accum,
  input wire logic [4:0] status,
  input wire logic done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire [15:0] w = instr_word;
  wire ad = w[15:10] == 6'h09;
  wire tk = instr_valid && ext_set_enable_bit && !w[8] && w[7:0] <= 8'h5F && (ad || w[15:12] == 4'h8 || w[15:8] == 8'h68);
  take_done_a: assert property (tk |=> done) else $error("late done");
  no_done_a: assert property (!tk |=> !done) else $error("stray done");
  big_ofs_a: assert property (w[7:0] > 8'h5F |=> !done) else $error("offset");
  bank_sel_a: assert property (w[8] |=> !done) else $error("bank");
  add_mem_a: assert property (tk && ad && w[9] |=> $stable(accum)) else $error("accum");
  add_flag_a: assert property (tk && ad && !w[9] |=> status[2] == !accum && status[4] == accum[7])
    else $error("flags");
  bit_keep_a: assert property (tk && w[15] |=> $stable(status)) else $error("bit flags");
  fill_keep_a: assert property (tk && w[14] |=> $stable({status, accum})) else $error("fill");
endmodule
bind iod_decode iod_chk iod_chk_inst (.*);
`default_nettype wire

// ---- tb/testbench.sv ----
// Decoder bench
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk = 0, sys_rst = 1, ext_set_enable_bit = 1, instr_valid = 0, fp_load = 0, accum_load = 0, mem_wr = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [11:0] fp_value = 12'h000, mem_addr = 12'h000;
  logic [7:0] accum_value = 8'h00, mem_wdata = 8'h00, mem_rdata, accum;
  logic [11:0] frame_pointer;
  logic [4:0] status;
  logic done, indexed_hit;
  int num_errors = 0, checks = 0;
  iod_decode iod_decode_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .ext_set_enable_bit(ext_set_enable_bit),
    .instr_valid(instr_valid), .instr_word(instr_word), .fp_load(fp_load), .fp_value(fp_value),
    .accum_load(accum_load), .accum_value(accum_value), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .frame_pointer(frame_pointer), .accum(accum),
    .status(status), .done(done), .indexed_hit(indexed_hit));
  initial forever #5 sys_clk = ~sys_clk;
  task ck(input logic [11:0] s, e);
    checks++;
    if (s !== e) num_errors++;
    if (s !== e) $display("wrong value at %0t: got %h expected %h", $time, s, e);
  endtask
  task results;
    $display("errors %0d of %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task ld(input logic [11:0] f, a, input logic [7:0] x, d);
    @(posedge sys_clk) #1 {fp_value, mem_addr, accum_value, mem_wdata} = {f, a, x, d};
    {fp_load, accum_load, mem_wr} = 3'h7;
    @(posedge sys_clk) #1 {fp_load, accum_load, mem_wr} = 3'h0;
  endtask
  task op(input logic [15:0] w, input logic [11:0] a, input logic [7:0] e, d);
    @(posedge sys_clk) #1 {instr_valid, instr_word, mem_addr} = {1'b1, w, a};
    @(posedge sys_clk) #1 instr_valid = 0;
    ck(done, d);
    @(posedge sys_clk) #1 ck(mem_rdata, e);
  endtask
  task t_run;
    ld(12'hA00, 12'hA2C, 8'h17, 8'h20);
    op(16'h242C, 12'hA2C, 8'h20, 1'h1);
    ck(accum, 8'h37);
    op(16'h262C, 12'hA2C, 8'h57, 1'h1);
    op(16'h242C, 12'hA2C, 8'h57, 1'h1);
    ck(status, 5'h18);
    ld(12'hFFF, 12'h009, 8'h00, 8'h55);
    op(16'h8E0A, 12'h009, 8'hD5, 1'h1);
    op(16'h685F, 12'h05E, 8'hFF, 1'h1);
    $display("run test over");
  endtask
  task t_ref;
    ext_set_enable_bit = 0;
    op(16'h680A, 12'h009, 8'hD5, 1'h0);
    ext_set_enable_bit = 1;
    op(16'h6860, 12'h009, 8'hD5, 1'h0);
    op(16'h690A, 12'h009, 8'hD5, 1'h0);
    $display("refusal test over");
  endtask
  task t_zero;
    ld(12'h000, 12'h02C, 8'h01, 8'h10);
    ck(frame_pointer, 12'h000);
    op(16'h242C, 12'h02C, 8'h10, 1'h1);
    ck(accum, 8'h11);
    @(posedge sys_clk) #1 {instr_valid, instr_word} = {1'b1, 16'h0005};
    @(posedge sys_clk) #1 instr_valid = 0;
    ck(indexed_hit, 1'h1);
    ck(done, 1'h0);
    $display("zero pointer test over");
  endtask
  initial begin
    #96 sys_rst = 0;
    t_run;
    t_ref;
    t_zero;
    results;
  end
  initial begin
    #3000 num_errors++;
    results;
  end
endmodule
`default_nettype wire
